//--- cwp_regs.svh
// Summary of operation
// RULE_01: Reads always allowed; writes follow mask bits.
// RULE_02: Protected command needs a matching password first.
// RULE_03: Two password kinds: public and private.
// RULE_04: Each store keeps its own mask, private password.
// RULE_05: Default mask bit clear needs default private password.
// RULE_06: User mask bit clear needs user private password.
// RULE_07: Level 0..3 read in bits 1:0, rest zero.
// RULE_08: Levels 0-1 public; levels 2-3 need private.
// RULE_09: Private password write never lowers the level.
// RULE_10: Public password write sets level 0 or 1.
// RULE_11: Default mask bit clear: writable at level 3.
// RULE_12: Default private password match raises level to 3.
// RULE_13: User mask bit clear: writable at level 2+.
// RULE_14: User private password match raises level to 2.
// RULE_15: Level 1 writes commands set in both masks.
// RULE_16: User public password match sets level 1.
// RULE_17: Default public password plays no part.
// RULE_18: Level 0 accepts only always-writable commands.
// RULE_19: Public password mismatch drops level to 0.
// RULE_20: Level register is read-only byte, resets to 01h.
// RULE_21: Vendor should protect default save/reload commands.
// RULE_22: User should protect user/default save/reload commands.
// RULE_23: Mask has 256 bits, bit n for code n.
// RULE_24: Masks reset all ones; default needs 3, user 2+.
// RULE_25: Public password is four bytes, never protected.
// RULE_26: Refused writes leave the command parameter unchanged.
`ifndef CWP_REGS_SVH
`define CWP_REGS_SVH

// Command codes handled by the protection logic itself.
`define CMD_ACCESS_TIER 8'hFA
`define CMD_PRIV_PWD 8'hFB
`define CMD_PUB_PWD 8'hFC
`define CMD_WRITE_MASK 8'hFD

// Register fields, widths and reset values.
`define TIER_FIELD_MSB 1
`define TIER_FIELD_LSB 0
`define TIER_RESET 8'h01
`define MASK_BITS 256
`define MASK_RESET {256{1'b1}}
`define PWD_BITS 32
`define PUB_PWD_RESET 32'h0000_0000
`define PRIV_PWD_RESET 32'h0000_0000

`endif

//--- cwp_pkg.sv
package cwp_pkg;
   // Security tier, coded exactly as software reads it back.
   typedef enum logic [1:0] {
      TIER_0 = 2'h0,
      TIER_1 = 2'h1,
      TIER_2 = 2'h2,
      TIER_3 = 2'h3
   } tier_t;
   typedef logic [255:0] mask_t;
   typedef logic [31:0] pwd_t;
   typedef logic [7:0] code_t;
endpackage

//--- gate_if.sv
`timescale 1ns/10ps
`default_nettype none
interface gate_if;
   cwp_pkg::tier_t tier;
   logic dflt_bit;
   logic user_bit;
   logic always_wr;
   logic allow;
   modport asker (output tier, output dflt_bit, output user_bit,
      output always_wr, input allow);
   modport judge (input tier, input dflt_bit, input user_bit,
      input always_wr, output allow);
endinterface
`default_nettype wire

//--- write_gate.sv
`timescale 1ns/10ps
`default_nettype none
module write_gate (
   gate_if.judge g
);
   // The default store is checked first, so a bit cleared there can only
   // be opened by the vendor tier even if the user store leaves it set.
   wire need_three = !g.dflt_bit; // RULE_05
   wire need_two = g.dflt_bit && !g.user_bit; // RULE_06
   wire ok_three = (g.tier == cwp_pkg::TIER_3); // RULE_11
   wire ok_two = (g.tier >= cwp_pkg::TIER_2); // RULE_13
   wire ok_one = (g.tier >= cwp_pkg::TIER_1); // RULE_15

   // Tier 0 passes only commands that are never protected.
   assign g.allow = g.always_wr ? 1'b1 :
                    need_three ? ok_three :
                    need_two ? ok_two : ok_one; // RULE_18
endmodule
`default_nettype wire

//--- command_write_protection.sv
`timescale 1ns/10ps
`default_nettype none
`include "cwp_regs.svh"
module command_write_protection (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic cmd_wr_valid,
   input wire logic [7:0] cmd_wr_code,
   input wire logic [255:0] cmd_wr_data,
   input wire logic cmd_wr_dflt,
   input wire logic cmd_rd_valid,
   input wire logic [7:0] cmd_rd_code,
   input wire logic nvm_load,
   input wire logic nvm_load_dflt,
   input wire logic [255:0] nvm_mask,
   input wire logic [31:0] nvm_priv,
   input wire logic [31:0] nvm_pub,
   output logic rd_allow,
   output logic wr_accept,
   output logic wr_refused,
   output logic [7:0] access_tier_status,
   output logic [255:0] dflt_mask_out,
   output logic [255:0] user_mask_out
);
   // Per-store protection state: one mask and one private password each.
   cwp_pkg::mask_t dflt_mask_q; // RULE_04
   cwp_pkg::mask_t user_mask_q;
   cwp_pkg::pwd_t dflt_priv_q;
   cwp_pkg::pwd_t user_priv_q;
   cwp_pkg::pwd_t user_pub_q;
   cwp_pkg::tier_t tier_q;
   cwp_pkg::tier_t tier_d;
   logic wr_accept_q;
   logic wr_refused_q;

   // Command decode of the incoming write.
   wire is_pub = (cmd_wr_code == `CMD_PUB_PWD);
   wire is_priv = (cmd_wr_code == `CMD_PRIV_PWD);
   wire is_mask = (cmd_wr_code == `CMD_WRITE_MASK);
   wire is_tier = (cmd_wr_code == `CMD_ACCESS_TIER);
   wire is_general = !is_pub && !is_priv && !is_mask && !is_tier;
   wire pub_wr = cmd_wr_valid && is_pub; // RULE_25
   wire priv_wr = cmd_wr_valid && is_priv;
   wire [31:0] pwd_in = cmd_wr_data[`PWD_BITS-1:0];

   // Password comparisons; only the user store's public password counts.
   wire pub_match = (pwd_in == user_pub_q); // RULE_17
   wire dflt_priv_match = (pwd_in == dflt_priv_q);
   wire user_priv_match = (pwd_in == user_priv_q);

   // Mask bit lookup: bit n of each mask guards command code n.
   wire dflt_bit = dflt_mask_q[cmd_wr_code]; // RULE_23
   wire user_bit = user_mask_q[cmd_wr_code];

   // The shared decision for ordinary commands lives in the gate.
   gate_if gif ();
   assign gif.tier = tier_q;
   assign gif.dflt_bit = dflt_bit;
   assign gif.user_bit = user_bit;
   assign gif.always_wr = is_pub || is_priv; // RULE_18
   write_gate u_gate (
      .g(gif.judge)
   );

   // Mask writes carry their own tier needs and bypass the mask itself,
   // otherwise a cleared bit could lock the store out for good.
   wire mask_ok = cmd_wr_dflt ? (tier_q == cwp_pkg::TIER_3) :
                  (tier_q >= cwp_pkg::TIER_2); // RULE_24
   wire allow = is_mask ? mask_ok :
                is_tier ? 1'b0 : gif.allow; // RULE_02
   wire mask_wr = cmd_wr_valid && is_mask && mask_ok;

   // Tier update. A public password always resets to 0 or 1; a private
   // password only ever raises, so a tier-2 match never drops tier 3.
   assign tier_d = pub_wr ?
                   (pub_match ? cwp_pkg::TIER_1 : // RULE_16
                    cwp_pkg::TIER_0) : // RULE_19
                   (priv_wr && dflt_priv_match) ? cwp_pkg::TIER_3 : // RULE_12
                   (priv_wr && user_priv_match &&
                    (tier_q < cwp_pkg::TIER_2)) ? cwp_pkg::TIER_2 : // RULE_14
                   tier_q; // RULE_09 RULE_10

   // Security tier register, reset to tier 1.
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         tier_q <= cwp_pkg::tier_t'(2'(`TIER_RESET)); // RULE_20
      end else begin
         tier_q <= tier_d; // RULE_08
      end
   end

   // Default store contents; a restore load wins over a host mask write.
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         dflt_mask_q <= `MASK_RESET; // RULE_24
         dflt_priv_q <= `PRIV_PWD_RESET;
      end else if (nvm_load && nvm_load_dflt) begin
         dflt_mask_q <= nvm_mask;
         dflt_priv_q <= nvm_priv;
      end else if (mask_wr && cmd_wr_dflt) begin
         dflt_mask_q <= cmd_wr_data;
      end
   end

   // User store contents, including the public password in use.
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         user_mask_q <= `MASK_RESET;
         user_priv_q <= `PRIV_PWD_RESET;
         user_pub_q <= `PUB_PWD_RESET;
      end else if (nvm_load && !nvm_load_dflt) begin
         user_mask_q <= nvm_mask;
         user_priv_q <= nvm_priv;
         user_pub_q <= nvm_pub; // RULE_03
      end else if (mask_wr && !cmd_wr_dflt) begin
         user_mask_q <= cmd_wr_data;
      end
   end

   // Verdict pulses one cycle after the write. The owner of the command's
   // parameter must drop the write on a refusal; only mask writes are stored here.
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         wr_accept_q <= 1'b0;
         wr_refused_q <= 1'b0;
      end else begin
         wr_accept_q <= cmd_wr_valid && allow; // RULE_26
         wr_refused_q <= cmd_wr_valid && !allow;
      end
   end

   // Outputs. Reads are never gated by any mask or tier.
   assign rd_allow = cmd_rd_valid; // RULE_01
   assign wr_accept = wr_accept_q;
   assign wr_refused = wr_refused_q;
   assign access_tier_status = {6'h00, tier_q}; // RULE_07
   assign dflt_mask_out = dflt_mask_q;
   assign user_mask_out = user_mask_q;

   // Checks of the tier logic and the write verdicts.
   a_pub_match_one: assert property ( // RULE_16
      @(posedge ref_clk) disable iff (!resetn)
      pub_wr && pub_match |=> access_tier_status == 8'h01)
      else $error("Public password match did not give tier 1.");

   a_pub_miss_zero: assert property ( // RULE_19
      @(posedge ref_clk) disable iff (!resetn)
      pub_wr && !pub_match |=> access_tier_status == 8'h00)
      else $error("Public password mismatch did not give tier 0.");

   a_priv_no_lower: assert property ( // RULE_09
      @(posedge ref_clk) disable iff (!resetn)
      priv_wr |=> tier_q >= $past(tier_q))
      else $error("Private password write lowered the tier.");

   a_dflt_priv_three: assert property ( // RULE_12
      @(posedge ref_clk) disable iff (!resetn)
      priv_wr && dflt_priv_match |=> tier_q == cwp_pkg::TIER_3)
      else $error("Default private password did not give tier 3.");

   a_user_priv_two: assert property ( // RULE_14
      @(posedge ref_clk) disable iff (!resetn)
      priv_wr && user_priv_match && !dflt_priv_match &&
      tier_q < cwp_pkg::TIER_2 |=> tier_q == cwp_pkg::TIER_2)
      else $error("User private password did not give tier 2.");

   a_dflt_bit_guard: assert property ( // RULE_11
      @(posedge ref_clk) disable iff (!resetn)
      cmd_wr_valid && is_general && !dflt_bit &&
      tier_q != cwp_pkg::TIER_3 |=> wr_refused && !wr_accept)
      else $error("Default-protected command written below tier 3.");

   a_user_bit_guard: assert property ( // RULE_13
      @(posedge ref_clk) disable iff (!resetn)
      cmd_wr_valid && is_general && dflt_bit && !user_bit |=>
      wr_accept == ($past(tier_q) >= cwp_pkg::TIER_2))
      else $error("User-protected command verdict wrong for tier.");

   a_tier0_locked: assert property ( // RULE_18
      @(posedge ref_clk) disable iff (!resetn)
      cmd_wr_valid && tier_q == cwp_pkg::TIER_0 && !is_pub && !is_priv
      |=> wr_refused)
      else $error("Tier 0 accepted a protectable command.");

   a_tier1_open: assert property ( // RULE_15
      @(posedge ref_clk) disable iff (!resetn)
      cmd_wr_valid && is_general && dflt_bit && user_bit &&
      tier_q == cwp_pkg::TIER_1 |=> wr_accept)
      else $error("Tier 1 refused an open command.");

   a_tier_held: assert property ( // RULE_20
      @(posedge ref_clk) disable iff (!resetn)
      !pub_wr && !priv_wr |=> $stable(access_tier_status))
      else $error("Tier changed without a password write.");

   a_dflt_mask_lock: assert property ( // RULE_24
      @(posedge ref_clk) disable iff (!resetn)
      cmd_wr_valid && is_mask && cmd_wr_dflt && !nvm_load &&
      tier_q != cwp_pkg::TIER_3 |=> $stable(dflt_mask_q) ##1 1'b1)
      else $error("Default mask changed below tier 3.");

   a_verdict_one: assert property ( // RULE_02
      @(posedge ref_clk) disable iff (!resetn)
      cmd_wr_valid |=> wr_accept != wr_refused)
      else $error("Write got no verdict or two verdicts.");

   a_reads_free: assert property ( // RULE_01
      @(posedge ref_clk) disable iff (!resetn)
      cmd_rd_valid |-> rd_allow)
      else $error("A read was refused.");

   // Further checks on verdicts, stores and tier movement.
   a_tier_upper_zero: assert property ( // RULE_07
      @(posedge ref_clk) disable iff (!resetn)
      access_tier_status[7:2] == 6'h00)
      else $error("Unused tier status bits not zero.");

   a_no_idle_verdict: assert property ( // RULE_26
      @(posedge ref_clk) disable iff (!resetn)
      !cmd_wr_valid |=> !wr_accept && !wr_refused)
      else $error("Verdict without a write.");

   a_tier_wr_refused: assert property ( // RULE_20
      @(posedge ref_clk) disable iff (!resetn)
      cmd_wr_valid && is_tier |=> wr_refused)
      else $error("Write to the tier register accepted.");

   a_pub_always_open: assert property ( // RULE_25
      @(posedge ref_clk) disable iff (!resetn)
      pub_wr |=> wr_accept)
      else $error("Public password write refused.");

   a_priv_always_open: assert property ( // RULE_03
      @(posedge ref_clk) disable iff (!resetn)
      priv_wr |=> wr_accept)
      else $error("Private password write refused.");

   a_user_mask_lock: assert property ( // RULE_24
      @(posedge ref_clk) disable iff (!resetn)
      cmd_wr_valid && is_mask && !cmd_wr_dflt && !nvm_load &&
      tier_q < cwp_pkg::TIER_2 |=> $stable(user_mask_q))
      else $error("User mask changed below tier 2.");

   a_dflt_mask_write: assert property ( // RULE_24
      @(posedge ref_clk) disable iff (!resetn)
      cmd_wr_valid && is_mask && cmd_wr_dflt && !nvm_load &&
      tier_q == cwp_pkg::TIER_3 |=> dflt_mask_q == $past(cmd_wr_data))
      else $error("Default mask write at tier 3 lost.");

   a_user_mask_write: assert property ( // RULE_24
      @(posedge ref_clk) disable iff (!resetn)
      cmd_wr_valid && is_mask && !cmd_wr_dflt && !nvm_load &&
      tier_q >= cwp_pkg::TIER_2 |=> user_mask_q == $past(cmd_wr_data))
      else $error("User mask write at tier 2 or 3 lost.");

   a_dflt_load: assert property ( // RULE_04
      @(posedge ref_clk) disable iff (!resetn)
      nvm_load && nvm_load_dflt |=> dflt_mask_q == $past(nvm_mask) &&
      dflt_priv_q == $past(nvm_priv))
      else $error("Default store restore lost.");

   a_user_load: assert property ( // RULE_04
      @(posedge ref_clk) disable iff (!resetn)
      nvm_load && !nvm_load_dflt |=> user_mask_q == $past(nvm_mask) &&
      user_priv_q == $past(nvm_priv) && user_pub_q == $past(nvm_pub))
      else $error("User store restore lost.");

   a_dflt_store_kept: assert property ( // RULE_04
      @(posedge ref_clk) disable iff (!resetn)
      !(nvm_load && nvm_load_dflt) && !(mask_wr && cmd_wr_dflt) |=>
      $stable(dflt_mask_q) && $stable(dflt_priv_q))
      else $error("Default store changed on its own.");

   a_user_store_kept: assert property ( // RULE_04
      @(posedge ref_clk) disable iff (!resetn)
      !(nvm_load && !nvm_load_dflt) && !(mask_wr && !cmd_wr_dflt) |=>
      $stable(user_mask_q) && $stable(user_priv_q) && $stable(user_pub_q))
      else $error("User store changed on its own.");

   a_priv_miss_kept: assert property ( // RULE_09
      @(posedge ref_clk) disable iff (!resetn)
      priv_wr && !dflt_priv_match && !user_priv_match |=> $stable(tier_q))
      else $error("Unmatched private password moved the tier.");

   a_high_tier_kept: assert property ( // RULE_09
      @(posedge ref_clk) disable iff (!resetn)
      priv_wr && !dflt_priv_match && tier_q >= cwp_pkg::TIER_2 |=>
      $stable(tier_q))
      else $error("User private password moved a high tier.");

   a_dflt_bit_open: assert property ( // RULE_05
      @(posedge ref_clk) disable iff (!resetn)
      cmd_wr_valid && is_general && !dflt_bit &&
      tier_q == cwp_pkg::TIER_3 |=> wr_accept)
      else $error("Tier 3 refused a default-protected command.");

   a_high_only_public: assert property ( // RULE_08
      @(posedge ref_clk) disable iff (!resetn)
      !pub_wr && tier_q >= cwp_pkg::TIER_2 |=> tier_q >= cwp_pkg::TIER_2)
      else $error("High tier left without a public password.");

   a_priv_reach_high: assert property ( // RULE_08
      @(posedge ref_clk) disable iff (!resetn)
      priv_wr && (dflt_priv_match || user_priv_match) |=>
      tier_q >= cwp_pkg::TIER_2)
      else $error("Private password match gave a low tier.");

   a_pub_caps_one: assert property ( // RULE_10
      @(posedge ref_clk) disable iff (!resetn)
      pub_wr |=> tier_q <= cwp_pkg::TIER_1)
      else $error("Public password write left a high tier.");

   a_mask_verdict: assert property ( // RULE_24
      @(posedge ref_clk) disable iff (!resetn)
      cmd_wr_valid && is_mask |=> wr_accept == $past(mask_ok))
      else $error("Mask write verdict wrong for tier.");

   a_read_no_tier: assert property ( // RULE_01
      @(posedge ref_clk) disable iff (!resetn)
      cmd_rd_valid && !cmd_wr_valid |=> $stable(tier_q))
      else $error("A read moved the tier.");

   a_tier1_guarded: assert property ( // RULE_15
      @(posedge ref_clk) disable iff (!resetn)
      cmd_wr_valid && is_general && tier_q == cwp_pkg::TIER_1 &&
      !(dflt_bit && user_bit) |=> wr_refused)
      else $error("Tier 1 accepted a masked command.");

   // Main scenarios worth seeing.
   c_reach_three: cover property (
      @(posedge ref_clk) disable iff (!resetn)
      tier_q == cwp_pkg::TIER_1 ##1 tier_q == cwp_pkg::TIER_3);
   c_reach_two: cover property (
      @(posedge ref_clk) disable iff (!resetn)
      tier_q == cwp_pkg::TIER_0 ##1 tier_q == cwp_pkg::TIER_2);
   c_drop_from_three: cover property (
      @(posedge ref_clk) disable iff (!resetn)
      tier_q == cwp_pkg::TIER_3 ##1 tier_q == cwp_pkg::TIER_0);
   c_mask_written: cover property (
      @(posedge ref_clk) disable iff (!resetn)
      mask_wr ##1 wr_accept);
   c_tier_read: cover property (
      @(posedge ref_clk) disable iff (!resetn)
      cmd_rd_valid && cmd_rd_code == `CMD_ACCESS_TIER);
endmodule
`default_nettype wire

//--- cwp_host.sv
`timescale 1ns/10ps
`default_nettype none
module cwp_host (
   input wire logic ref_clk,
   output logic wr_valid,
   output logic [7:0] wr_code,
   output logic [255:0] wr_data,
   output logic wr_dflt,
   output logic rd_valid,
   output logic [7:0] rd_code
);
   // Bus idle at time zero.
   initial begin
      wr_valid = 1'b0;
      wr_code = 8'h00;
      wr_data = {256{1'b0}};
      wr_dflt = 1'b0;
      rd_valid = 1'b0;
      rd_code = 8'h00;
   end
   // One whole command per call; a password rides in the low four bytes.
   task automatic send(input logic [7:0] c, input logic [255:0] d,
         input logic f);
      @(posedge ref_clk);
      wr_valid <= 1'b1;
      wr_code <= c;
      wr_data <= d;
      wr_dflt <= f;
      @(posedge ref_clk);
      wr_valid <= 1'b0;
      // Released lines show the inverse, so nothing leans on stale values.
      wr_code <= ~c;
      wr_data <= ~d;
      wr_dflt <= ~f;
   endtask
   // A read is a one-cycle strobe with its code.
   task automatic read(input logic [7:0] c);
      @(posedge ref_clk);
      rd_valid <= 1'b1;
      rd_code <= c;
      @(posedge ref_clk);
      rd_valid <= 1'b0;
      rd_code <= ~c;
   endtask
endmodule
`default_nettype wire

//--- tb_command_write_protection.sv
`timescale 1ns/10ps
`default_nettype none
`include "cwp_regs.svh"
module tb_command_write_protection;
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   logic nvm_load = 1'b0;
   logic nvm_load_dflt = 1'b0;
   logic [255:0] nvm_mask = {256{1'b0}};
   logic [31:0] nvm_priv = 32'h0000_0000;
   logic [31:0] nvm_pub = 32'h0000_0000;
   wire logic wv, wf, rv, rd_allow, wr_accept, wr_refused;
   wire logic [7:0] wc, rc, access_tier_status;
   wire logic [255:0] wd, dflt_mask_out, user_mask_out;
   logic [1:0] tier = 2'h1;
   cwp_pkg::mask_t dm = `MASK_RESET, um = `MASK_RESET;
   cwp_pkg::pwd_t dp = 32'h0, up = 32'h0, pp = 32'h0, dq = 32'h0;
   logic [9:0] exp_q[$];
   int n_fail = 0;
   int check_count = 0;
   int cyc = 0;
   localparam logic [7:0] save_code = 8'h10; // Arbitrary stand-in code.
   always #5 ref_clk = ~ref_clk;
   cwp_host u_host (.ref_clk(ref_clk), .wr_valid(wv), .wr_code(wc),
      .wr_data(wd), .wr_dflt(wf), .rd_valid(rv), .rd_code(rc));
   command_write_protection u_dut (.ref_clk(ref_clk), .resetn(resetn),
      .cmd_wr_valid(wv), .cmd_wr_code(wc), .cmd_wr_data(wd),
      .cmd_wr_dflt(wf), .cmd_rd_valid(rv), .cmd_rd_code(rc),
      .nvm_load(nvm_load), .nvm_load_dflt(nvm_load_dflt),
      .nvm_mask(nvm_mask), .nvm_priv(nvm_priv), .nvm_pub(nvm_pub),
      .rd_allow(rd_allow), .wr_accept(wr_accept), .wr_refused(wr_refused),
      .access_tier_status(access_tier_status),
      .dflt_mask_out(dflt_mask_out), .user_mask_out(user_mask_out));
   task automatic check(input logic [259:0] seen, input logic [259:0] want);
      check_count++;
      if (seen !== want) begin
         n_fail++;
         $display("unexpected at %0t: seen %0h expected %0h", $time, seen,
            want);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   function automatic logic [255:0] rnd256();
      logic [255:0] r;
      for (int i = 0; i < 8; i++) begin
         r[i*32 +: 32] = $urandom();
      end
      return r;
   endfunction
   // Writability as the tier and the two masks decide it.
   function automatic logic verdict(input logic [7:0] c, input logic f);
      if (c == `CMD_ACCESS_TIER) return 1'b0;
      if (c == `CMD_PRIV_PWD || c == `CMD_PUB_PWD) return 1'b1;
      if (c == `CMD_WRITE_MASK) return f ? tier == 2'h3 : tier >= 2'h2;
      if (!dm[c]) return tier == 2'h3;
      if (!um[c]) return tier >= 2'h2;
      return tier >= 2'h1;
   endfunction
   // Predict the verdict and tier, note them, then send the command.
   task automatic wr(input logic [7:0] c, input logic [255:0] d,
         input logic f);
      logic ok;
      ok = verdict(c, f);
      if (c == `CMD_PUB_PWD) tier = (d[31:0] === pp) ? 2'h1 : 2'h0;
      else if (c == `CMD_PRIV_PWD && d[31:0] === dp) tier = 2'h3;
      else if (c == `CMD_PRIV_PWD && d[31:0] === up && tier < 2'h2) tier = 2'h2;
      else if (c == `CMD_WRITE_MASK && ok && f) dm = d;
      else if (c == `CMD_WRITE_MASK && ok) um = d;
      exp_q.push_back({ok, !ok, 6'h00, tier});
      u_host.send(c, d, f);
   endtask
   // Restore one store; the default store's public password is kept aside.
   task automatic load(input logic f);
      logic [255:0] m;
      logic [31:0] p, q;
      m = rnd256();
      m[save_code] = 1'b0;
      p = $urandom();
      q = $urandom();
      if (f) begin
         dm = m;
         dp = p;
         dq = q;
      end else begin
         um = m;
         up = p;
         pp = q;
      end
      @(posedge ref_clk);
      nvm_load <= 1'b1;
      nvm_load_dflt <= f;
      nvm_mask <= m;
      nvm_priv <= p;
      nvm_pub <= q;
      @(posedge ref_clk);
      nvm_load <= 1'b0;
   endtask
   // Each verdict pulse is paired with the oldest note; a hang is cut off.
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         report_and_stop();
      end
      if (resetn) begin
         check(rd_allow, rv);
         if (wr_accept || wr_refused) begin
            if (exp_q.size() > 0) begin
               check({wr_accept, wr_refused, access_tier_status}, exp_q.pop_front());
            end else begin
               check(1'b1, 1'b0);
            end
         end
      end
   end
   // Mixed traffic: passwords right and wrong, mask writes, protected codes.
   initial begin
      logic [255:0] d;
      logic [7:0] c;
      int k;
      k = $urandom(32'hFD9F);
      repeat (12) @(posedge ref_clk);
      resetn <= 1'b1;
      @(posedge ref_clk);
      check(access_tier_status, `TIER_RESET);
      check(dflt_mask_out, `MASK_RESET);
      check(user_mask_out, `MASK_RESET);
      load(1'b1);
      load(1'b0);
      for (int i = 0; i < 400; i++) begin
         k = $urandom_range(7);
         d = rnd256();
         c = d[255:248];
         case (k)
            0: d[31:0] = pp;
            1: d[31:0] = dp;
            2: d[31:0] = up;
            3: d[31:0] = dq;
            default: ;
         endcase
         if (k == 0 || k == 3) c = `CMD_PUB_PWD;
         if (k == 1 || k == 2) c = `CMD_PRIV_PWD;
         if (k == 4) c = `CMD_WRITE_MASK;
         if (k == 5) c = `CMD_ACCESS_TIER;
         wr(c, d, d[8]);
         if (k == 7) u_host.read(c);
         if (i == 200) load(1'b0);
      end
      repeat (3) @(posedge ref_clk);
      check(exp_q.size(), 0);
      check(dflt_mask_out, dm);
      check(user_mask_out, um);
      report_and_stop();
   end
endmodule
`default_nettype wire
